// File: hw/mmp_pkg.sv
// Purpose: Constants for the multi-mode PWM timer block.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes: The rules below carry no tags that mark the logic carrying them out.
// Operation
// - Two-bit mode field picks four modes.
// - Standard: active at phase, inactive at duty.
// - Standard: period match resets timer.
// - Standard period is (period+1) times prescale; the code gives (period+1) times (prescale+1) clocks.
// - Offset match event synchronises timer, three modes.
// - Set-on-match: phase match sets output, sticky.
// - Set-on-match ignores duty; period bounds timer.
// - Output-level writes apply at next PWM tick.
// - Toggle: 50% output, twice standard period.
// - Toggle: phase counts periods before toggling.
// - Toggle ignores output-level writes.
// - Center: count up to period, then down.
// - Center: set counting up, clear counting down.
// - Center: up match period-duty, down plus one.
// - Center ignores output-level writes.
package mmp_pkg;
   localparam logic [7:0] mmp_adr_ctrl = 8'h00;
   localparam logic [7:0] mmp_adr_period = 8'h04;
   localparam logic [7:0] mmp_adr_duty = 8'h08;
   localparam logic [7:0] mmp_adr_phase = 8'h0c;
   localparam logic [7:0] mmp_adr_offset = 8'h10;
   localparam logic [7:0] mmp_adr_presc = 8'h14;
   localparam logic [7:0] mmp_adr_timer = 8'h18;
   localparam int mmp_ctrl_en_bit = 0;
   localparam int mmp_ctrl_mode_lsb = 1;
   localparam int mmp_ctrl_out_bit = 3;
   localparam int mmp_ctrl_ofs_lsb = 4;
   localparam int mmp_ctrl_pol_bit = 6;
   localparam int mmp_stat_out_bit = 7;
   localparam logic [1:0] mmp_mode_std = 2'h0;
   localparam logic [1:0] mmp_mode_set = 2'h1;
   localparam logic [1:0] mmp_mode_tog = 2'h2;
   localparam logic [1:0] mmp_mode_ctr = 2'h3;
   localparam logic [1:0] mmp_ofs_none = 2'h0;
   localparam logic [1:0] mmp_ofs_reset = 2'h1;
   localparam logic [1:0] mmp_ofs_start = 2'h2;
   localparam logic [1:0] mmp_ofs_stop = 2'h3;
   localparam logic [15:0] mmp_rst_count = 16'h0000;
   localparam logic [7:0] mmp_rst_presc = 8'h00;
endpackage

// File: hw/mmp_timer.sv
// Purpose: Multi-mode PWM generator with Wishbone register access.
// Assumes: One clock; prescaler gives the PWM tick; the offset event comes from a pin.
// Notes: Bus answers one cycle after a request; unmapped reads return zero.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module mmp_timer #(
   parameter int CW = 16
) (
   input wire logic clock, // System clock, 10 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [7:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   input wire logic offset_match_in, // Offset match event pin, asynchronous.
   output logic pwm_out // PWM output pin.
);
   typedef enum logic [2:0] {
      mmp_up = 3'b001,
      mmp_down = 3'b010,
      mmp_halt = 3'b100
   } mmp_dir_t;

   typedef struct packed {
      logic enable;
      logic [1:0] mode;
      logic output_level_bit;
      logic level_pending;
      logic [1:0] ofs_mode;
      logic polarity;
      logic [CW-1:0] period_count;
      logic [CW-1:0] duty_cycle_count;
      logic [CW-1:0] phase_count;
      logic [7:0] presc;
      logic [7:0] presc_cnt;
      logic [CW-1:0] pwm_timer;
      logic [CW-1:0] tog_cnt;
      mmp_dir_t dir;
      logic active;
      logic pin_level;
      logic [2:0] ofs_sync;
      logic ofs_level;
      logic ack;
      logic [31:0] rdata;
   } mmp_state_t;

   mmp_state_t s;
   mmp_state_t next_s;
   logic tick;
   logic ofs_event;
   logic req;
   logic [CW-1:0] up_match;

   assign req = wb_cyc_i & wb_stb_i & ~s.ack;
   assign tick = s.enable && (s.presc_cnt == s.presc);
   // The pin counts as changed only once the second and third stages agree,
   // so a glitch shorter than one clock never moves the timer.
   assign ofs_event = s.ofs_sync[1] & s.ofs_sync[2] & ~s.ofs_level;
   assign up_match = CW'(s.period_count - s.duty_cycle_count);

   always_comb begin
      logic [CW-1:0] rd;
      logic [31:0] wd;
      rd = '0;
      wd = wb_dat_i;
      next_s = s;
      next_s.ack = req;
      next_s.ofs_sync = {s.ofs_sync[1:0], offset_match_in};
      if (s.ofs_sync[1] == s.ofs_sync[2]) begin
         next_s.ofs_level = s.ofs_sync[2];
      end
      if (req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == mmp_pkg::mmp_adr_ctrl) begin
            next_s.enable = wd[mmp_pkg::mmp_ctrl_en_bit];
            next_s.mode = wd[mmp_pkg::mmp_ctrl_mode_lsb +: 2];
            next_s.output_level_bit = wd[mmp_pkg::mmp_ctrl_out_bit];
            next_s.level_pending = 1'b1;
            next_s.ofs_mode = wd[mmp_pkg::mmp_ctrl_ofs_lsb +: 2];
            next_s.polarity = wd[mmp_pkg::mmp_ctrl_pol_bit];
         end else if (wb_adr_i == mmp_pkg::mmp_adr_period) begin
            next_s.period_count = wd[CW-1:0];
         end else if (wb_adr_i == mmp_pkg::mmp_adr_duty) begin
            next_s.duty_cycle_count = wd[CW-1:0];
         end else if (wb_adr_i == mmp_pkg::mmp_adr_phase) begin
            next_s.phase_count = wd[CW-1:0];
         end else if (wb_adr_i == mmp_pkg::mmp_adr_presc) begin
            next_s.presc = wd[7:0];
         end
      end
      if (wb_adr_i == mmp_pkg::mmp_adr_ctrl) begin
         rd = CW'({s.active, s.polarity, s.ofs_mode, s.output_level_bit, s.mode, s.enable});
      end else if (wb_adr_i == mmp_pkg::mmp_adr_period) begin
         rd = s.period_count;
      end else if (wb_adr_i == mmp_pkg::mmp_adr_duty) begin
         rd = s.duty_cycle_count;
      end else if (wb_adr_i == mmp_pkg::mmp_adr_phase) begin
         rd = s.phase_count;
      end else if (wb_adr_i == mmp_pkg::mmp_adr_presc) begin
         rd = CW'(s.presc);
      end else if (wb_adr_i == mmp_pkg::mmp_adr_timer) begin
         rd = s.pwm_timer;
      end
      next_s.rdata = req ? 32'(rd) : 32'h0;

      if (!s.enable) begin
         // Disable acts as the block reset.
         next_s.pwm_timer = '0;
         next_s.active = 1'b0;
         next_s.presc_cnt = '0;
         next_s.tog_cnt = '0;
         next_s.dir = mmp_up;
      end else begin
         next_s.presc_cnt = tick ? 8'h00 : 8'(s.presc_cnt + 8'h01);
         if (tick) begin
            case (s.mode)
               mmp_pkg::mmp_mode_std: begin
                  if (s.pwm_timer == s.phase_count) next_s.active = 1'b1;
                  if (s.pwm_timer == s.duty_cycle_count) next_s.active = 1'b0;
                  next_s.pwm_timer = (s.pwm_timer >= s.period_count) ? '0 : CW'(s.pwm_timer + 1'b1);
               end
               mmp_pkg::mmp_mode_set: begin
                  // Duty count is not looked at here.
                  if (s.pwm_timer == s.phase_count && s.phase_count <= s.period_count) begin
                     next_s.active = 1'b1;
                  end
                  if (s.level_pending) begin
                     next_s.active = s.output_level_bit;
                     next_s.level_pending = 1'b0;
                  end
                  next_s.pwm_timer = (s.pwm_timer >= s.period_count) ? '0 : CW'(s.pwm_timer + 1'b1);
               end
               mmp_pkg::mmp_mode_tog: begin
                  // Output-level writes never reach the output here.
                  next_s.level_pending = 1'b0;
                  if (s.pwm_timer >= s.period_count) begin
                     next_s.pwm_timer = '0;
                     if (s.tog_cnt >= s.phase_count) begin
                        next_s.active = ~s.active;
                        next_s.tog_cnt = '0;
                     end else begin
                        next_s.tog_cnt = CW'(s.tog_cnt + 1'b1);
                     end
                  end else begin
                     next_s.pwm_timer = CW'(s.pwm_timer + 1'b1);
                  end
               end
               default: begin
                  next_s.level_pending = 1'b0;
                  if (s.dir == mmp_up) begin
                     if (s.pwm_timer == up_match) next_s.active = 1'b1;
                     if (s.pwm_timer >= s.period_count) begin
                        next_s.dir = mmp_down;
                        next_s.pwm_timer = CW'(s.pwm_timer - 1'b1);
                     end else begin
                        next_s.pwm_timer = CW'(s.pwm_timer + 1'b1);
                     end
                  end else begin
                     if (s.pwm_timer == CW'(up_match + 1'b1)) next_s.active = 1'b0;
                     if (s.pwm_timer == '0) begin
                        next_s.dir = mmp_up;
                        next_s.pwm_timer = CW'(1);
                     end else begin
                        next_s.pwm_timer = CW'(s.pwm_timer - 1'b1);
                     end
                  end
               end
            endcase
         end
      end
      // The resync pulse lasts one clock, so it acts at once instead of waiting
      // for a prescaler tick that would usually miss it.
      if (s.enable && s.mode != mmp_pkg::mmp_mode_ctr && s.ofs_mode != mmp_pkg::mmp_ofs_none && ofs_event) begin
         next_s.pwm_timer = '0;
         next_s.tog_cnt = '0;
         next_s.presc_cnt = '0;
      end
      // The pin level is registered with the state so the output cannot glitch.
      next_s.pin_level = next_s.active ^ next_s.polarity;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{
            enable: 1'b0,
            mode: mmp_pkg::mmp_mode_std,
            output_level_bit: 1'b0,
            level_pending: 1'b0,
            ofs_mode: mmp_pkg::mmp_ofs_none,
            polarity: 1'b0,
            period_count: mmp_pkg::mmp_rst_count,
            duty_cycle_count: mmp_pkg::mmp_rst_count,
            phase_count: mmp_pkg::mmp_rst_count,
            presc: mmp_pkg::mmp_rst_presc,
            presc_cnt: 8'h00,
            pwm_timer: mmp_pkg::mmp_rst_count,
            tog_cnt: mmp_pkg::mmp_rst_count,
            dir: mmp_up,
            active: 1'b0,
            pin_level: 1'b0,
            ofs_sync: 3'h0,
            ofs_level: 1'b0,
            ack: 1'b0,
            rdata: 32'h0
         };
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdata;
   assign pwm_out = s.pin_level;

   a_disable_quiet: assert property (
      @(posedge clock) disable iff (!reset_n)
      !s.enable
      |=> s.pwm_timer == '0 && !s.active
   ) else $error("Disabled timer not idle");

   a_std_wrap: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_std && s.pwm_timer >= s.period_count
      |=> s.pwm_timer == '0
   ) else $error("Standard timer did not wrap");

   a_std_clear: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_std && s.pwm_timer == s.duty_cycle_count
      |=> !s.active
   ) else $error("Duty match did not clear");

   a_std_set: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_std && s.pwm_timer == s.phase_count && s.pwm_timer != s.duty_cycle_count
      |=> s.active
   ) else $error("Phase match did not set");

   a_timer_hold: assert property (
      @(posedge clock) disable iff (!reset_n)
      s.enable && !tick && !ofs_event
      |=> $stable(s.pwm_timer)
   ) else $error("Timer moved between ticks");

   a_out_hold: assert property (
      @(posedge clock) disable iff (!reset_n)
      s.enable && !tick
      |=> $stable(s.active)
   ) else $error("Output moved between ticks");

   a_tick_rate: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.presc == 8'h01 && $past(s.enable)
      |=> !tick ##1 (tick || !s.enable)
   ) else $error("Prescaler rate wrong");

   a_set_level: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_set && s.level_pending
      |=> s.active == $past(s.output_level_bit)
   ) else $error("Level write not applied");

   a_set_phase: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_set && s.pwm_timer == s.phase_count && s.phase_count <= s.period_count
      && !s.level_pending
      |=> s.active
   ) else $error("Set match did not set");

   a_set_sticky: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_set && s.active && !s.level_pending
      |=> s.active
   ) else $error("Set output dropped");

   a_set_wrap: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_set && s.pwm_timer >= s.period_count
      |=> s.pwm_timer == '0
   ) else $error("Set timer passed period");

   a_tog_levels: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_tog && s.pwm_timer < s.period_count
      |=> $stable(s.active)
   ) else $error("Toggle changed mid period");

   a_tog_flip: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_tog && s.pwm_timer >= s.period_count && s.tog_cnt >= s.phase_count
      |=> s.active != $past(s.active)
   ) else $error("Toggle missed its period");

   a_tog_wait: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_tog && s.pwm_timer >= s.period_count && s.tog_cnt < s.phase_count
      |=> $stable(s.active)
   ) else $error("Toggle came too early");

   a_ctr_set: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_ctr && s.dir == mmp_up && s.pwm_timer == up_match
      |=> s.active
   ) else $error("Center up match did not set");

   a_ctr_clear: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_ctr && s.dir == mmp_down && s.pwm_timer == CW'(up_match + 1'b1)
      |=> !s.active
   ) else $error("Center down match did not clear");

   a_ctr_rise_only: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_ctr && s.dir == mmp_up && s.pwm_timer != up_match
      |=> $stable(s.active)
   ) else $error("Center output moved off match");

   a_ctr_turn: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_ctr && s.dir == mmp_up && s.pwm_timer >= s.period_count
      |=> s.dir == mmp_down
   ) else $error("Center did not turn at period");

   a_ctr_floor: assert property (
      @(posedge clock) disable iff (!reset_n)
      tick && s.mode == mmp_pkg::mmp_mode_ctr && s.dir == mmp_down && s.pwm_timer == '0
      |=> s.dir == mmp_up && s.pwm_timer == CW'(1)
   ) else $error("Center did not turn at zero");

   a_ofs_resync: assert property (
      @(posedge clock) disable iff (!reset_n)
      s.enable && s.mode != mmp_pkg::mmp_mode_ctr && s.ofs_mode != mmp_pkg::mmp_ofs_none && ofs_event
      |=> s.pwm_timer == '0
   ) else $error("Offset event did not resync");

   a_bus_ack: assert property (
      @(posedge clock) disable iff (!reset_n)
      req
      |=> wb_ack_o ##1 !wb_ack_o
   ) else $error("Ack timing wrong");

   a_read_idle: assert property (
      @(posedge clock) disable iff (!reset_n)
      !wb_ack_o
      |-> wb_dat_o == 32'h0
   ) else $error("Read data without ack");

   c_std_run: cover property (@(posedge clock) s.mode == mmp_pkg::mmp_mode_std && $rose(s.active));
   c_tog_run: cover property (@(posedge clock) s.mode == mmp_pkg::mmp_mode_tog && $fell(s.active));
   c_ctr_run: cover property (@(posedge clock) s.mode == mmp_pkg::mmp_mode_ctr && s.dir == mmp_down);
   c_set_run: cover property (@(posedge clock) s.mode == mmp_pkg::mmp_mode_set && $rose(s.active));
   c_ofs_run: cover property (@(posedge clock) s.enable && ofs_event);
endmodule

// File: dv/multi_mode_pwm_timer_tb.sv
// Purpose: Self-checking bench for the multi-mode PWM timer.
// Assumes: Bus acks within a few cycles; prescale 1 gives one tick every two clocks.
// Notes: Waveforms are timed by edge-to-edge counts, so fixed pipeline delays cancel out.
`timescale 1ns/1ps
module multi_mode_pwm_timer_tb;
   logic clock, reset_n, cyc, stb, we, ofs_in, ack, pwm;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   int err_count, total_checks;

   mmp_timer #(.CW(16)) DUT (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .offset_match_in(ofs_in), .pwm_out(pwm));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // The request stands until a rising edge samples ack high; read data is taken at that edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) chk("bus ack", 32'h1, 32'h0);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   function automatic logic [31:0] cw(input logic [1:0] m, input logic o, input logic [1:0] f);
      return {26'h0, f, o, m, 1'b1};
   endfunction

   task automatic setup(input logic [1:0] m, input logic [15:0] pr, dc, ph, pc);
      wr(mmp_pkg::mmp_adr_ctrl, 32'h0);
      wr(mmp_pkg::mmp_adr_period, {16'h0, pr});
      wr(mmp_pkg::mmp_adr_duty, {16'h0, dc});
      wr(mmp_pkg::mmp_adr_phase, {16'h0, ph});
      wr(mmp_pkg::mmp_adr_presc, {16'h0, pc});
      wr(mmp_pkg::mmp_adr_ctrl, cw(m, 1'b0, 2'h0));
   endtask

   task automatic meas(output int hi, output int per);
      int n;
      n = 0;
      while (pwm !== 1'b0 && n < 500) begin @(negedge clock); n++; end
      while (pwm !== 1'b1 && n < 1000) begin @(negedge clock); n++; end
      hi = 0;
      while (pwm === 1'b1 && hi < 500) begin @(negedge clock); hi++; end
      per = hi;
      while (pwm === 1'b0 && per < 1000) begin @(negedge clock); per++; end
   endtask

   task automatic t_reset();
      logic [7:0] adrs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'hfc};
      foreach (adrs[i]) begin
         bus(1'b0, adrs[i], 32'h0, q);
         chk("reset read", 32'h0, q);
      end
      chk("reset pwm", 32'h0, {31'h0, pwm});
   endtask

   // The second pass writes the output-level bit, which these modes must not honour.
   task automatic run_mode(input logic [1:0] m, input logic [15:0] pr, dc, ph, input int ehi, eper, two);
      int hi, per;
      setup(m, pr, dc, ph, 16'h1);
      meas(hi, per);
      chk("high time", ehi, hi);
      chk("period", eper, per);
      if (two) begin
         wr(mmp_pkg::mmp_adr_ctrl, cw(m, 1'b1, 2'h0));
         meas(hi, per);
         chk("high time level set", ehi, hi);
         chk("period level set", eper, per);
      end
   endtask

   task automatic t_set();
      setup(mmp_pkg::mmp_mode_set, 16'h9, 16'h6, 16'hc, 16'h1);
      repeat (60) @(negedge clock);
      chk("set no match", 32'h0, {31'h0, pwm});
      wr(mmp_pkg::mmp_adr_ctrl, cw(mmp_pkg::mmp_mode_set, 1'b1, 2'h0));
      repeat (4) @(negedge clock);
      chk("set by level", 32'h1, {31'h0, pwm});
      bus(1'b0, mmp_pkg::mmp_adr_ctrl, 32'h0, q);
      chk("ctrl readback", cw(mmp_pkg::mmp_mode_set, 1'b1, 2'h0) | (32'h1 << mmp_pkg::mmp_stat_out_bit), q);
      wr(mmp_pkg::mmp_adr_ctrl, cw(mmp_pkg::mmp_mode_set, 1'b0, 2'h0));
      repeat (4) @(negedge clock);
      chk("clear by level", 32'h0, {31'h0, pwm});
      wr(mmp_pkg::mmp_adr_phase, 32'h3);
      repeat (24) @(negedge clock);
      chk("set on phase", 32'h1, {31'h0, pwm});
      repeat (60) @(negedge clock);
      chk("set sticky", 32'h1, {31'h0, pwm});
      wr(mmp_pkg::mmp_adr_ctrl, 32'h0);
      repeat (2) @(negedge clock);
      chk("disabled out", 32'h0, {31'h0, pwm});
      bus(1'b0, mmp_pkg::mmp_adr_timer, 32'h0, q);
      chk("disabled timer", 32'h0, q);
      wr(mmp_pkg::mmp_adr_ctrl, 32'h1 << mmp_pkg::mmp_ctrl_pol_bit);
      repeat (2) @(negedge clock);
      chk("inverted idle", 32'h1, {31'h0, pwm});
      wr(mmp_pkg::mmp_adr_ctrl, 32'h0);
   endtask

   // A slow prescale keeps the timer nearly still across the resync read.
   task automatic t_ofs();
      setup(mmp_pkg::mmp_mode_std, 16'hffff, 16'h0, 16'h0, 16'hff);
      wr(mmp_pkg::mmp_adr_ctrl, cw(mmp_pkg::mmp_mode_std, 1'b0, mmp_pkg::mmp_ofs_reset));
      repeat (3000) @(posedge clock);
      bus(1'b0, mmp_pkg::mmp_adr_timer, 32'h0, q);
      chk("timer runs", 32'h1, {31'h0, q > 32'h1});
      @(posedge clock);
      ofs_in <= 1'b1;
      repeat (2) @(posedge clock);
      ofs_in <= 1'b0;
      repeat (8) @(negedge clock);
      bus(1'b0, mmp_pkg::mmp_adr_timer, 32'h0, q);
      chk("offset resync", 32'h1, {31'h0, q <= 32'h1});
   endtask

   initial begin
      {reset_n, cyc, stb, we, ofs_in, adr, sel, wdat} = '0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      run_mode(mmp_pkg::mmp_mode_std, 16'h9, 16'h6, 16'h2, 8, 20, 0);
      run_mode(mmp_pkg::mmp_mode_tog, 16'h9, 16'h0, 16'h0, 20, 40, 1);
      run_mode(mmp_pkg::mmp_mode_ctr, 16'h9, 16'h4, 16'h0, 14, 36, 1);
      t_set();
      t_ofs();
      test_done();
   end

   initial begin
      repeat (40000) @(posedge clock);
      err_count++;
      test_done();
   end
endmodule
